// ===== tb/isa_printer_port_host_interface_test.sv
`timescale 1ns/1ps
module isa_printer_port_host_interface_test;
    logic       sys_clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       fifo_ready_i = 1'b0;
    logic       event_i = 1'b0;
    logic [7:0] status_i = 8'h5A;
    logic       cs_n_i, a10_i, ior_n_i, iow_n_i, aen_i, tc_i;
    logic [2:0] addr_i, dack_n_i, irq_n_o, irq_oe_n_o, drq_o, drq_oe_n_o;
    logic [7:0] data_i, data_o, fifo_data_o;
    logic       data_oe_n_o, iochrdy_o, iochrdy_oe_n_o, port_direction_indicator_o, fifo_valid_o;
    logic [7:0] q[$];
    int         errors = 0;
    int         tests_run = 0;
    int         stall_n = 0;
    int         wr_done = 0;
    int         full_at = 0;
    logic       refused = 1'b0;
    ppi_host_if uut (.sys_clk_i, .nrst_i, .cs_n_i, .a10_i, .addr_i, .ior_n_i, .iow_n_i, .aen_i,
        .tc_i, .dack_n_i, .data_i, .data_o, .data_oe_n_o, .iochrdy_o, .iochrdy_oe_n_o, .irq_n_o,
        .irq_oe_n_o, .drq_o, .drq_oe_n_o, .port_direction_indicator_o, .fifo_valid_o,
        .fifo_ready_i, .fifo_data_o, .status_i, .event_i);
    ppi_isa_host host (.clk_i(sys_clk_i), .dev_data_i(data_o), .dev_oe_n_i(data_oe_n_o),
        .iochrdy_i(iochrdy_o), .iochrdy_oe_n_i(iochrdy_oe_n_o), .drq_i(drq_o),
        .drq_oe_n_i(drq_oe_n_o), .cs_n_o(cs_n_i), .a10_o(a10_i), .addr_o(addr_i),
        .ior_n_o(ior_n_i), .iow_n_o(iow_n_i), .aen_o(aen_i), .tc_o(tc_i), .dack_n_o(dack_n_i),
        .data_o(data_i));
    always #2 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////
    // far side stalls until a writer has been held off for 40 cycles
    always @(posedge sys_clk_i) begin
        if (fifo_valid_o === 1'b1 && fifo_ready_i === 1'b1) begin
            q.push_back(fifo_data_o);
        end
        stall_n = (iochrdy_oe_n_o === 1'b0) ? stall_n + 1 : 0;
        if (stall_n == 40 && !fifo_ready_i) begin
            refused = 1'b1;
            full_at = wr_done;
            fifo_ready_i <= #1 1'b1;
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
        logic ok;
        host.io(wr, a, wd, 1'b0, 1'b0, rd, ok);
        if (!ok) begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic t_reset;
        logic [7:0] d;
        chk({data_oe_n_o, iochrdy_oe_n_o, irq_oe_n_o, drq_o}, 8'hF8);
        acc(1'b0, 4'hA, 8'h00, d);
        chk(d, 8'h15);
        acc(1'b0, 4'hB, 8'h00, d);
        chk(d, 8'h05);
    endtask
    task automatic t_decode;
        logic [7:0] d;
        logic       ok;
        acc(1'b0, 4'h1, 8'h00, d);
        chk(d, 8'h5A);
        host.io(1'b0, 4'h1, 8'h00, 1'b1, 1'b0, d, ok);
        chk(ok, 1'b0);
        host.io(1'b0, 4'h1, 8'h00, 1'b0, 1'b1, d, ok);
        chk(ok, 1'b0);
    endtask
    task automatic t_mode;
        logic [7:0] d;
        acc(1'b1, 4'h2, 8'h20, d);
        chk(port_direction_indicator_o, 1'b0);
        acc(1'b0, 4'hA, 8'h00, d);
        chk(d, 8'h15);
        acc(1'b1, 4'hA, 8'h20, d);
        chk(port_direction_indicator_o, 1'b1);
        acc(1'b1, 4'h2, 8'h00, d);
    endtask
    task automatic t_irq;
        logic [7:0] d;
        logic [2:0] m;
        for (int s = 0; s < 3; s++) begin
            m = ~(3'h1 << s);
            acc(1'b1, 4'hB, 8'h14 | 8'(s), d);
            chk(irq_oe_n_o, m);
            #1 event_i = 1'b1;
            repeat (2) @(posedge sys_clk_i);
            chk(irq_n_o, m);
            #1 event_i = 1'b0;
        end
        acc(1'b1, 4'hB, 8'h04, d);
        chk(irq_oe_n_o, 3'h7);
    endtask
    task automatic t_fifo;
        logic [7:0] d;
        acc(1'b1, 4'hA, 8'h60, d);
        q.delete();
        for (int i = 0; i < 24; i++) begin
            acc(1'b1, 4'h8, 8'hA0 + 8'(i), d);
            wr_done = i + 1;
        end
        for (int n = 0; n < 400 && q.size() < 24; n++) begin
            @(posedge sys_clk_i);
        end
        chk(refused, 1'b1);
        chk(8'(full_at), 8'h12);
        chk(8'(q.size()), 8'h18);
        if (q.size() < 24) begin
            end_of_test();
        end
        for (int i = 0; i < 24; i++) begin
            chk(q[i], 8'hA0 + 8'(i));
        end
    endtask
    task automatic t_dma;
        logic [7:0] d;
        q.delete();
        host.dv = 8'hC0;
        host.left = 4;
        acc(1'b1, 4'hA, 8'h68, d);
        for (int n = 0; n < 2000 && host.left != 0; n++) begin
            @(posedge sys_clk_i);
        end
        if (host.left != 0) begin
            errors++;
            end_of_test();
        end
        repeat (30) @(posedge sys_clk_i);
        chk(8'(host.ch), 8'h01);
        chk(8'(q.size()), 8'h04);
        chk(q[3], 8'hC3);
        chk(drq_o, 3'h0);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk_i);
        #1;
        nrst_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        t_reset();
        t_decode();
        t_mode();
        t_irq();
        t_fifo();
        t_dma();
        end_of_test();
    end
endmodule

// ===== tb/ppi_host_if_checker.sv
`timescale 1ns/1ps
module ppi_host_if_checker (
    input wire logic       sys_clk_i,
    input wire logic       nrst_i,
    input wire logic       cs_n_i,
    input wire logic       ior_n_i,
    input wire logic       iow_n_i,
    input wire logic       aen_i,
    input wire logic       tc_i,
    input wire logic [2:0] dack_n_i,
    input wire logic       data_oe_n_o,
    input wire logic       iochrdy_o,
    input wire logic       iochrdy_oe_n_o,
    input wire logic [2:0] irq_oe_n_o,
    input wire logic [2:0] drq_o,
    input wire logic [2:0] drq_oe_n_o,
    input wire logic       port_direction_indicator_o,
    input wire logic       fifo_valid_o,
    input wire logic       fifo_ready_i,
    input wire logic [7:0] fifo_data_o
);
    logic [3:0] ack_age;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////
    // saturating age of the last acknowledge, covers the input synchroniser delay
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_age <= 4'hF;
        end else if (dack_n_i != 3'h7) begin
            ack_age <= 4'h0;
        end else if (ack_age != 4'hF) begin
            ack_age <= ack_age + 4'h1;
        end
    end
    sequence rd_hold_s;
        (!ior_n_i && !cs_n_i && !aen_i) [*6];
    endsequence
    sequence tc_hit_s;
        (dack_n_i != 3'h7) && tc_i;
    endsequence
    reset_idle_a: assert property (
        $rose(nrst_i) |-> !port_direction_indicator_o && data_oe_n_o && drq_o == 3'h0)
        else $error("outputs active after reset");
    rd_answer_a: assert property (
        rd_hold_s |-> !data_oe_n_o) else $error("read not answered");
    rd_drive_a: assert property (
        $fell(data_oe_n_o) |-> !ior_n_i && (!cs_n_i && !aen_i || dack_n_i != 3'h7))
        else $error("data driven without a selected read");
    rd_release_a: assert property (
        ior_n_i [*8] |-> data_oe_n_o) else $error("data driven after read");
    rdy_cause_a: assert property (
        !iochrdy_oe_n_o |-> !iochrdy_o && (!iow_n_i || !ior_n_i))
        else $error("not-ready outside an access");
    irq_line_a: assert property (
        $onehot0(~irq_oe_n_o)) else $error("several interrupt lines driven");
    drq_line_a: assert property (
        $onehot0(~drq_oe_n_o) && (drq_o & drq_oe_n_o) == 3'h0)
        else $error("request on undriven channel");
    drq_hold_a: assert property (
        |($past(drq_o) & ~drq_o & ~drq_oe_n_o) |-> ack_age < 4'h9)
        else $error("request dropped before acknowledge");
    tc_end_a: assert property (
        tc_hit_s |-> ##12 (drq_o == 3'h0) [*8]) else $error("dma went on after terminal count");
    fifo_hold_a: assert property (
        fifo_valid_o && !fifo_ready_i |=> fifo_valid_o && $stable(fifo_data_o))
        else $error("stalled word changed");
endmodule
bind ppi_host_if ppi_host_if_checker chk_i (.sys_clk_i, .nrst_i, .cs_n_i, .ior_n_i, .iow_n_i,
    .aen_i, .tc_i, .dack_n_i, .data_oe_n_o, .iochrdy_o, .iochrdy_oe_n_o, .irq_oe_n_o, .drq_o,
    .drq_oe_n_o, .port_direction_indicator_o, .fifo_valid_o, .fifo_ready_i, .fifo_data_o);

// ===== tb/ppi_isa_host.sv
`timescale 1ns/1ps
module ppi_isa_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] dev_data_i,
    input  wire logic       dev_oe_n_i,
    input  wire logic       iochrdy_i,
    input  wire logic       iochrdy_oe_n_i,
    input  wire logic [2:0] drq_i,
    input  wire logic [2:0] drq_oe_n_i,
    output logic            cs_n_o,
    output logic            a10_o,
    output logic [2:0]      addr_o,
    output logic            ior_n_o,
    output logic            iow_n_o,
    output logic            aen_o,
    output logic            tc_o,
    output logic [2:0]      dack_n_o,
    output logic [7:0]      data_o
);
    logic [7:0] hd = 8'h00;
    logic [7:0] dv = 8'h00;
    int         left = 0;
    int         ch = -1;
    wire        rdy = iochrdy_oe_n_i | iochrdy_i;
    // released bus shows the inverted last byte, not a held copy
    assign data_o = dev_oe_n_i ? hd : dev_data_i;
    initial begin
        {cs_n_o, ior_n_o, iow_n_o, dack_n_o} = 6'h3F;
        {a10_o, addr_o, aen_o, tc_o} = 6'h00;
    end
    task automatic io(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                      input logic csn, input logic aen, output logic [7:0] rd, output logic ok);
        int lim;
        lim = (csn | aen) ? 20 : 400;
        ok = 1'b0;
        @(posedge clk_i);
        #1;
        cs_n_o = csn;
        aen_o = aen;
        {a10_o, addr_o} = a;
        if (wr) begin
            hd = wd;
            iow_n_o = 1'b0;
        end else begin
            ior_n_o = 1'b0;
        end
        for (int n = 0; n < lim && !ok; n++) begin
            @(posedge clk_i);
            ok = n >= 6 && rdy && (wr || !dev_oe_n_i);
        end
        rd = data_o;
        #1;
        {cs_n_o, ior_n_o, iow_n_o, aen_o} = 4'hE;
        hd = ~hd;
        repeat (6) @(posedge clk_i);
    endtask
    // dma controller: one write cycle per request while transfers remain
    always begin
        @(posedge clk_i);
        #1;
        if (left != 0 && cs_n_o && |(drq_i & ~drq_oe_n_i)) begin
            ch = drq_i[0] ? 0 : (drq_i[1] ? 1 : 2);
            // idle gap so the strobe edge of this cycle is seen apart from the last one
            repeat (2) @(posedge clk_i);
            #1;
            aen_o = 1'b1;
            dack_n_o[ch] = 1'b0;
            hd = dv;
            iow_n_o = 1'b0;
            tc_o = left == 1;
            for (int n = 0; n < 8 || (!rdy && n < 400); n++) begin
                @(posedge clk_i);
            end
            #1;
            {iow_n_o, aen_o, tc_o, dack_n_o} = 6'h27;
            hd = ~hd;
            dv = dv + 8'h01;
            left = left - 1;
            repeat (8) @(posedge clk_i);
        end
    end
endmodule

// ===== verilog/ppi_host_if.sv
`timescale 1ns/1ps
`include "ppi_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R01] after power-up behave as compatibility printer port; software may change mode
// [R02] 16-byte FIFO for ECP modes, filled by programmed I/O or DMA
// [R03] address bit 10 selects upper bank 0x400 above base
// [R04] data transfers only while chip select is low; DMA cycles transfer on the acknowledge whatever chip select is
// [R05] host read strobe low makes device drive selected register
// [R06] channel-ready pulled low while extra cycles are needed, else released
// [R07] interrupt on one selectable line 5/7/9, active low, three-stated otherwise
// [R08] AEN high means DMA controller owns address bus
// [R09] DRQ of selected channel held high until matching acknowledge low
// [R10] DMA controller answers with active-low acknowledge of same channel
// [R11] terminal count pulse during DMA ends the DMA operation
// [R12] reset enters output-only compatibility mode
// [R13] mode field writable only with address bit 10 set
// [R14] non-DMA FIFO service threshold fixed at 8 entries
// [R15] strobes ignored while AEN high and no acknowledge asserted
module ppi_host_if (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       cs_n_i,
    input  wire logic       a10_i,
    input  wire logic [2:0] addr_i,
    input  wire logic       ior_n_i,
    input  wire logic       iow_n_i,
    input  wire logic       aen_i,
    input  wire logic       tc_i,
    input  wire logic [2:0] dack_n_i,
    input  wire logic [7:0] data_i,
    output logic [7:0]      data_o,
    output logic            data_oe_n_o,
    output logic            iochrdy_o,
    output logic            iochrdy_oe_n_o,
    output logic [2:0]      irq_n_o,
    output logic [2:0]      irq_oe_n_o,
    output logic [2:0]      drq_o,
    output logic [2:0]      drq_oe_n_o,
    output logic            port_direction_indicator_o,
    output logic            fifo_valid_o,
    input  wire logic       fifo_ready_i,
    output logic [7:0]      fifo_data_o,
    input  wire logic [7:0] status_i,
    input  wire logic       event_i
);
    //////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // pins: cs, ior, iow, aen, tc, dack[2:0]
    logic [7:0] pin_raw;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] pin_q;
    assign pin_raw = {cs_n_i, ior_n_i, iow_n_i, aen_i, tc_i, dack_n_i};
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s1    <= 8'hF7;
            s2    <= 8'hF7;
            s3    <= 8'hF7;
            pin_q <= 8'hF7;
        end else begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
            // a change counts once two stages agree
            pin_q <= (s2 & s3) | (pin_q & (s2 ^ s3));
        end
    end
    logic       cs_n, ior_n, iow_n, aen, tc;
    logic [2:0] dack_n;
    assign {cs_n, ior_n, iow_n, aen, tc, dack_n} = pin_q;

    //////////////////////////////////////////////////////////////////////////
    // access decode
    function automatic logic [1:0] ch_index(input logic [1:0] sel);
        ch_index = (sel == 2'h0 || sel > 2'h2) ? 2'h0 : sel;
    endfunction

    logic [7:0] xctl;
    logic [7:0] cfg;
    logic [7:0] ctrl;
    logic [7:0] data_reg;
    logic [1:0] dma_ch;
    logic [1:0] irq_ch;
    logic       dma_ack;
    logic       cpu_ok;
    logic       rd_act, wr_act;
    logic       rd_q, wr_q;
    logic       rd_start, wr_start;
    ppi_pkg::ppi_mode_t mode;

    assign mode    = ppi_pkg::ppi_mode_t'(xctl[`PPI_XCTL_MODE_MSB:`PPI_XCTL_MODE_LSB]);
    assign dma_ch  = ch_index(cfg[`PPI_CFG_DMA_LSB +: 2]);
    assign irq_ch  = ch_index(cfg[`PPI_CFG_IRQ_LSB +: 2]);
    assign dma_ack = !dack_n[dma_ch];
    // aen high without ack is a dma address cycle
    assign cpu_ok  = !cs_n && !aen; // [R04] [R08] [R15]
    assign rd_act  = !ior_n && (cpu_ok || dma_ack); // [R05]
    assign wr_act  = !iow_n && (cpu_ok || dma_ack);
    assign rd_start = rd_act && !rd_q;
    assign wr_start = wr_act && !wr_q;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd_act;
            wr_q <= wr_act;
        end
    end

    logic ecp_fifo_sel;
    assign ecp_fifo_sel = (mode == ppi_pkg::PPI_MODE_ECP || mode == ppi_pkg::PPI_MODE_FFIFO);

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic       fifo_wr;
    logic       fifo_full;
    logic [4:0] fifo_cnt;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            xctl     <= `PPI_XCTL_RESET; // [R12] [R01]
            cfg      <= `PPI_CFG_RESET;
            ctrl     <= 8'h00;
            data_reg <= 8'h00;
        end else if (wr_start && !dma_ack) begin
            if (a10_i) begin // [R03]
                if (addr_i == `PPI_OFS_XCTL) begin
                    xctl <= data_i; // [R13] [R01]
                end
                if (addr_i == `PPI_OFS_CFG) begin
                    cfg <= data_i;
                end
            end else if (addr_i == `PPI_OFS_DATA) begin
                data_reg <= data_i;
            end else if (addr_i == `PPI_OFS_CTRL) begin
                ctrl <= data_i;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // fifo write path: upper data port or dma cycles
    logic       fifo_in_valid;
    logic       skid_ready;
    logic       skid_valid;
    logic [7:0] skid_data;
    logic [7:0] fifo_mem [`PPI_FIFO_DEPTH];
    logic [3:0] wptr, rptr;
    logic       fifo_pop;
    logic       fifo_pend;

    assign fifo_in_valid = wr_start && ecp_fifo_sel
                         && (dma_ack || (a10_i && addr_i == `PPI_OFS_DATA)); // [R02]
    ppi_skid u_skid (
        .clk_i       (sys_clk_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (fifo_in_valid || fifo_pend),
        .in_ready_o  (skid_ready),
        .in_data_i   (data_i),
        .out_valid_o (skid_valid),
        .out_ready_i (!fifo_full),
        .out_data_o  (skid_data)
    );
    assign fifo_full = (fifo_cnt == 5'h10);
    assign fifo_wr   = skid_valid && !fifo_full;
    assign fifo_pop  = fifo_valid_o && fifo_ready_i;
    assign fifo_valid_o = (fifo_cnt != 5'h00);
    assign fifo_data_o  = fifo_mem[rptr];

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wptr     <= 4'h0;
            rptr     <= 4'h0;
            fifo_cnt <= 5'h00;
            fifo_pend <= 1'b0;
        end else begin
            // a refused word waits here while the host is held off
            fifo_pend <= (fifo_in_valid || fifo_pend) && !skid_ready; // [R06]
            if (fifo_wr) begin
                wptr <= wptr + 4'h1;
            end
            if (fifo_pop) begin
                rptr <= rptr + 4'h1;
            end
            fifo_cnt <= fifo_cnt + {4'h0, fifo_wr} - {4'h0, fifo_pop};
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (fifo_wr) begin
            fifo_mem[wptr] <= skid_data;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read data and wait states
    logic [7:0] next_rdata;
    logic [7:0] rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (a10_i) begin
            case (addr_i)
                `PPI_OFS_DATA: next_rdata = fifo_data_o;
                `PPI_OFS_XCTL: next_rdata = {xctl[7:2], fifo_full, !fifo_valid_o};
                `PPI_OFS_CFG:  next_rdata = cfg;
                default:       next_rdata = 8'h00;
            endcase
        end else begin
            case (addr_i)
                `PPI_OFS_DATA:   next_rdata = data_reg;
                `PPI_OFS_STATUS: next_rdata = status_i;
                `PPI_OFS_CTRL:   next_rdata = ctrl;
                default:         next_rdata = 8'h00;
            endcase
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_start) begin
            rdata <= next_rdata;
        end
    end
    assign data_o      = rdata;
    assign data_oe_n_o = !(rd_act && rd_q);

    // hold the bus until read data is latched or the buffer accepts
    logic wait_need;
    assign wait_need = (rd_act && !rd_q) || ((fifo_in_valid || fifo_pend) && !skid_ready); // [R06]
    assign iochrdy_o      = 1'b0;
    assign iochrdy_oe_n_o = !wait_need; // [R06]

    //////////////////////////////////////////////////////////////////////////
    // dma request
    ppi_pkg::ppi_dma_t dma_st;
    logic              want_dma;
    logic              dma_term;
    assign want_dma = xctl[`PPI_XCTL_DMA_BIT] && ecp_fifo_sel && skid_ready
                    && !fifo_full && !dma_term;
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dma_st   <= ppi_pkg::PPI_DMA_IDLE;
            dma_term <= 1'b0;
        end else begin
            if (wr_start && a10_i && addr_i == `PPI_OFS_XCTL) begin
                dma_term <= 1'b0;
            end
            case (dma_st)
                ppi_pkg::PPI_DMA_IDLE: begin
                    if (want_dma) begin
                        dma_st <= ppi_pkg::PPI_DMA_REQ;
                    end
                end
                ppi_pkg::PPI_DMA_REQ: begin
                    if (dma_ack) begin // [R09] [R10]
                        dma_st <= ppi_pkg::PPI_DMA_ACK;
                    end
                end
                ppi_pkg::PPI_DMA_ACK: begin
                    if (tc) begin
                        dma_term <= 1'b1; // [R11]
                    end
                    if (!dma_ack) begin
                        dma_st <= ppi_pkg::PPI_DMA_IDLE;
                    end
                end
                default: dma_st <= ppi_pkg::PPI_DMA_IDLE;
            endcase
        end
    end
    always_comb begin
        drq_o      = 3'h0;
        drq_oe_n_o = 3'h7;
        drq_oe_n_o[dma_ch] = !xctl[`PPI_XCTL_DMA_BIT];
        drq_o[dma_ch] = (dma_st == ppi_pkg::PPI_DMA_REQ) && xctl[`PPI_XCTL_DMA_BIT]; // [R09]
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupts: held low on selected line while a source is active, others released
    logic irq_act;
    logic below_thr;
    assign below_thr = (fifo_cnt < `PPI_FIFO_THRESH); // [R14]
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_act <= 1'b0;
        end else begin
            irq_act <= event_i || (ecp_fifo_sel && !xctl[`PPI_XCTL_DMA_BIT] && below_thr)
                    || dma_term; // [R14] [R11]
        end
    end
    always_comb begin
        irq_n_o    = 3'h7;
        irq_oe_n_o = 3'h7;
        irq_oe_n_o[irq_ch] = !cfg[`PPI_CFG_IRQEN_BIT]; // [R07]
        irq_n_o[irq_ch]    = !irq_act; // [R07]
    end

    assign port_direction_indicator_o = ctrl[5] && (mode != ppi_pkg::PPI_MODE_SPP);
endmodule

// ===== verilog/ppi_pkg.sv
package ppi_pkg;
    typedef enum logic [2:0] {
        PPI_MODE_SPP   = 3'h0,
        PPI_MODE_BIDIR = 3'h1,
        PPI_MODE_FFIFO = 3'h2,
        PPI_MODE_ECP   = 3'h3,
        PPI_MODE_EPP   = 3'h4,
        PPI_MODE_RSV5  = 3'h5,
        PPI_MODE_TEST  = 3'h6,
        PPI_MODE_CFG   = 3'h7
    } ppi_mode_t;
    typedef enum logic [2:0] {
        PPI_DMA_IDLE = 3'b001,
        PPI_DMA_REQ  = 3'b010,
        PPI_DMA_ACK  = 3'b100
    } ppi_dma_t;
endpackage

// ===== verilog/ppi_regs.svh
`ifndef PPI_REGS_SVH
`define PPI_REGS_SVH
// local offsets (A2..A0)
`define PPI_OFS_DATA      3'h0
`define PPI_OFS_STATUS    3'h1
`define PPI_OFS_CTRL      3'h2
`define PPI_OFS_XCTL      3'h2
// upper bank selected by address bit 10, 0x400 above base
`define PPI_UPPER_OFS     11'h400
// extended control register fields
`define PPI_XCTL_MODE_MSB 7
`define PPI_XCTL_MODE_LSB 5
`define PPI_XCTL_DMA_BIT  3
`define PPI_XCTL_RESET    8'h15
// FIFO
`define PPI_FIFO_DEPTH    16
`define PPI_FIFO_THRESH   5'h08
// configuration register fields (upper bank offset 3)
`define PPI_OFS_CFG       3'h3
`define PPI_CFG_IRQ_LSB   0
`define PPI_CFG_DMA_LSB   2
`define PPI_CFG_IRQEN_BIT 4
`define PPI_CFG_RESET     8'h05
`endif

// ===== verilog/ppi_skid.sv
`timescale 1ns/1ps
// two-entry buffer; ready depends only on occupancy
module ppi_skid (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       in_valid_i,
    output logic            in_ready_o,
    input  wire logic [7:0] in_data_i,
    output logic            out_valid_o,
    input  wire logic       out_ready_i,
    output logic [7:0]      out_data_o
);
    logic [7:0] buf_q [2];
    logic [1:0] cnt;
    logic       rd_ptr;
    logic       wr_ptr;
    logic       push;
    logic       pop;

    assign in_ready_o  = (cnt != 2'h2);
    assign out_valid_o = (cnt != 2'h0);
    assign out_data_o  = buf_q[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt    <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else begin
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            buf_q[wr_ptr] <= in_data_i;
        end
    end
endmodule
